// ==== hdl/sram_tap_pkg.sv ====
package sram_tap_pkg;

  localparam int IR_WIDTH        = 3;
  localparam int BSR_WIDTH       = 75;
  localparam int ID_WIDTH        = 32;
  localparam int RESET_TMS_EDGES = 5;

  localparam logic [2:0] INSN_EXT_TEST   = 3'h0;
  localparam logic [2:0] INSN_READ_ID    = 3'h1;
  localparam logic [2:0] INSN_SAMPLE_HIZ = 3'h2;
  localparam logic [2:0] INSN_RESERVED   = 3'h3;
  localparam logic [2:0] INSN_SAMPLE     = 3'h4;
  localparam logic [2:0] INSN_BYPASS     = 3'h7;

  localparam logic [1:0] IR_CAPTURE_PATTERN = 2'h1;
  localparam logic       IR_CAPTURE_TOP     = 1'h0;
  localparam logic       BYPASS_CAPTURE     = 1'h0;

  // Arbitrary neutral identification value; bit 0 marks an identification register.
  localparam logic [31:0] ID_WORD_DEFAULT = 32'h0000_0001;

  typedef enum logic [15:0] {
    TLR        = 16'h0001,
    RUN_IDLE   = 16'h0002,
    SEL_DR     = 16'h0004,
    CAPTURE_DR = 16'h0008,
    SHIFT_DR   = 16'h0010,
    EXIT1_DR   = 16'h0020,
    PAUSE_DR   = 16'h0040,
    EXIT2_DR   = 16'h0080,
    UPDATE_DR  = 16'h0100,
    SEL_IR     = 16'h0200,
    CAPTURE_IR = 16'h0400,
    SHIFT_IR   = 16'h0800,
    EXIT1_IR   = 16'h1000,
    PAUSE_IR   = 16'h2000,
    EXIT2_IR   = 16'h4000,
    UPDATE_IR  = 16'h8000
  } tap_state_t;

  typedef enum logic [2:0] {
    PATH_BYPASS = 3'h1,
    PATH_ID     = 3'h2,
    PATH_RING   = 3'h4
  } data_path_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } link_in_t;

  localparam link_in_t LINK_IDLE = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};

endpackage

// ==== hdl/sync_stage.sv ====
`timescale 1ns/1ps
module sync_stage #(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] firstStage;

  // Two flip-flops; only the second stage is visible outside.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      firstStage <= RESET_VALUE;
      dout       <= RESET_VALUE;
    end else begin
      firstStage <= din;
      dout       <= firstStage;
    end
  end

endmodule

// ==== hdl/sram_boundary_scan_tap.sv ====
// Operation
// R1 - Inputs sampled at test clock rise; serial output changes only at fall.
// R2 - Mode select sampled at rise; reads high when left open.
// R3 - Serial data enters each register at MSB, leaves at LSB.
// R4 - Serial output driven only in shift states, otherwise high impedance.
// R5 - Five rising edges with mode select high reach the reset state.
// R6 - Power-up reset leaves the serial output in high impedance.
// R7 - One data register in the path, chosen by the held instruction.
// R8 - Instruction register is three bits, holds identification read after reset.
// R9 - Capture-instruction loads pattern 01 into the two lowest bits.
// R10 - One-bit bypass register cleared on capture, sole path element.
// R11 - 75-bit ring register captures pins, then shifts out.
// R12 - Identification read captures a fixed 32-bit word and shifts it out.
// R13 - Instructions shift in serially, take effect at update-instruction.
// R14 - Three codes are reserved; the controller must not load them. The bench controller loads all eight codes.
// R15 - Code 000 captures like sample and forces memory outputs high impedance.
// R16 - Sample-high-impedance selects the ring register and forces outputs off.
// R17 - Sample captures pin values without disturbing memory operation.
// R18 - Update-data under sample changes nothing.
// R19 - The port never drives values into the memory; it only observes.
// R20 - Test clock at most 10 MHz; sampled signals held stable by controller.
// R21 - Codes: 000 ext-test, 001 id, 010 sample-hiz, 011 reserved, 100 sample.
// R22 - Standard sixteen-state controller stepped by mode select at each rise.
// R23 - Codes 111, 101 and 110 select the bypass register.
`timescale 1ns/1ps
module sram_boundary_scan_tap
  import sram_tap_pkg::*;
#(
  parameter int          BSR_LEN = BSR_WIDTH,
  parameter logic [31:0] ID_WORD = ID_WORD_DEFAULT
) (
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic               tck,
  input  wire logic               tms,
  input  wire logic               tdi,
  input  wire logic [BSR_LEN-1:0] ioRing,
  output logic                    tdo,
  output logic                    tdoOe,
  output logic                    outputsHighZ
);

  generate
    if (BSR_LEN < 2) begin : g_len_check
      $error("BSR_LEN must be at least two");
    end
  endgenerate

  link_in_t            linkRaw;
  link_in_t            linkSync;
  logic [BSR_LEN-1:0]  ringSync;
  logic                tckPrev;
  logic                tckRise;
  logic                tckFall;
  tap_state_t          state;
  tap_state_t          next_state;
  logic [IR_WIDTH-1:0] irShift;
  logic [IR_WIDTH-1:0] irActive;
  logic                bypassBit;
  logic [ID_WIDTH-1:0] idShift;
  logic [BSR_LEN-1:0]  pinScanChain;
  data_path_t          path;
  logic                next_tdo;

  assign linkRaw = '{tck: tck, tms: tms, tdi: tdi};

  // Pins cross into sys_clk through two flip-flops; idle levels follow the pull-ups.
  sync_stage #(
    .WIDTH       ($bits(link_in_t)),
    .RESET_VALUE (LINK_IDLE)
  ) u_link_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .din     (linkRaw),
    .dout    (linkSync)
  );

  sync_stage #(
    .WIDTH       (BSR_LEN),
    .RESET_VALUE ('0)
  ) u_ring_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .din     (ioRing),
    .dout    (ringSync)
  );

  function automatic tap_state_t tap_next(input tap_state_t cur, input logic m);
    tap_state_t nxt;
    nxt = TLR;
    case (cur)
      TLR:        nxt = m ? TLR : RUN_IDLE;
      RUN_IDLE:   nxt = m ? SEL_DR : RUN_IDLE;
      SEL_DR:     nxt = m ? SEL_IR : CAPTURE_DR;
      CAPTURE_DR: nxt = m ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR:   nxt = m ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR:   nxt = m ? UPDATE_DR : PAUSE_DR;
      PAUSE_DR:   nxt = m ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR:   nxt = m ? UPDATE_DR : SHIFT_DR;
      UPDATE_DR:  nxt = m ? SEL_DR : RUN_IDLE;
      SEL_IR:     nxt = m ? TLR : CAPTURE_IR;
      CAPTURE_IR: nxt = m ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR:   nxt = m ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR:   nxt = m ? UPDATE_IR : PAUSE_IR;
      PAUSE_IR:   nxt = m ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR:   nxt = m ? UPDATE_IR : SHIFT_IR;
      UPDATE_IR:  nxt = m ? SEL_DR : RUN_IDLE;
      default:    nxt = TLR;
    endcase
    return nxt;
  endfunction

  function automatic data_path_t insn_path(input logic [IR_WIDTH-1:0] insn);
    data_path_t p;
    p = PATH_BYPASS;
    case (insn)
      INSN_EXT_TEST, INSN_SAMPLE_HIZ, INSN_SAMPLE: p = PATH_RING;
      INSN_READ_ID:                                p = PATH_ID;
      default:                                     p = PATH_BYPASS;
    endcase
    return p;
  endfunction

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tckPrev <= 1'b0;
    end else begin
      tckPrev <= linkSync.tck;
    end
  end

  assign tckRise = linkSync.tck & ~tckPrev; // R1
  assign tckFall = ~linkSync.tck & tckPrev; // R1

  assign next_state = tap_next(state, linkSync.tms); // R2 R22

  // Power-up reset and five high mode-select edges both land in TLR.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= TLR; // R6
    end else if (tckRise) begin
      state <= next_state; // R5 R22
    end
  end

  // Instruction shift register.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irShift <= INSN_READ_ID;
    end else if (tckRise) begin
      if (state == CAPTURE_IR) begin
        irShift <= {IR_CAPTURE_TOP, IR_CAPTURE_PATTERN}; // R9
      end else if (state == SHIFT_IR) begin
        irShift <= {linkSync.tdi, irShift[IR_WIDTH-1:1]}; // R3 R13
      end
    end
  end

  // Held instruction; changes only in TLR or at the falling test clock edge in update-instruction.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irActive <= INSN_READ_ID; // R8
    end else if (state == TLR) begin
      irActive <= INSN_READ_ID; // R8
    end else if (tckFall && state == UPDATE_IR) begin
      irActive <= irShift; // R13
    end
  end

  assign path = insn_path(irActive); // R7 R14 R21 R23

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bypassBit <= BYPASS_CAPTURE;
    end else if (tckRise && path == PATH_BYPASS) begin
      if (state == CAPTURE_DR) begin
        bypassBit <= BYPASS_CAPTURE; // R10
      end else if (state == SHIFT_DR) begin
        bypassBit <= linkSync.tdi; // R10
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      idShift <= '0;
    end else if (tckRise && path == PATH_ID) begin
      if (state == CAPTURE_DR) begin
        idShift <= ID_WORD; // R12
      end else if (state == SHIFT_DR) begin
        idShift <= {linkSync.tdi, idShift[ID_WIDTH-1:1]}; // R3 R12
      end
    end
  end

  // Ring register only observes pins; update-data leaves it alone.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pinScanChain <= '0;
    end else if (tckRise && path == PATH_RING) begin
      if (state == CAPTURE_DR) begin
        pinScanChain <= ringSync; // R11 R15 R17 R19
      end else if (state == SHIFT_DR) begin
        pinScanChain <= {linkSync.tdi, pinScanChain[BSR_LEN-1:1]}; // R3 R11 R16
      end
    end
  end

  always_comb begin
    next_tdo = 1'b0;
    if (state == SHIFT_IR) begin
      next_tdo = irShift[0]; // R3
    end else begin
      case (path)
        PATH_RING: next_tdo = pinScanChain[0]; // R7
        PATH_ID:   next_tdo = idShift[0]; // R7
        default:   next_tdo = bypassBit; // R7 R10
      endcase
    end
  end

  // Serial output is updated only on the falling test clock edge.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tdo   <= 1'b0;
      tdoOe <= 1'b0; // R6
    end else if (tckFall) begin
      tdo   <= next_tdo; // R1
      tdoOe <= (state == SHIFT_DR) || (state == SHIFT_IR); // R4
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      outputsHighZ <= 1'b0;
    end else begin
      outputsHighZ <= (irActive == INSN_EXT_TEST) || (irActive == INSN_SAMPLE_HIZ); // R15 R16
    end
  end

  logic [2:0] tmsHighEdges;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tmsHighEdges <= '0;
    end else if (tckRise) begin
      if (!linkSync.tms) begin
        tmsHighEdges <= '0;
      end else if (tmsHighEdges != 3'h7) begin
        tmsHighEdges <= tmsHighEdges + 3'h1;
      end
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking

  default disable iff (!rst_n);

  property p_state_on_rise;
    !$stable(state) |-> $past(tckRise);
  endproperty
  a_state_on_rise: assert property (p_state_on_rise) // R1
    else $error("controller state moved without a test clock rise");

  property p_tdo_on_fall;
    !$stable(tdo) || !$stable(tdoOe) |-> $past(tckFall);
  endproperty
  a_tdo_on_fall: assert property (p_tdo_on_fall) // R1
    else $error("serial output changed without a test clock fall");

  property p_ring_shift_msb;
    tckRise && state == SHIFT_DR && path == PATH_RING |=>
      pinScanChain[BSR_LEN-1] == $past(linkSync.tdi) &&
      pinScanChain[BSR_LEN-2:0] == $past(pinScanChain[BSR_LEN-1:1]);
  endproperty
  a_ring_shift_msb: assert property (p_ring_shift_msb) // R3
    else $error("ring register did not shift toward the low bit");

  property p_oe_shift_only;
    tckFall |=> tdoOe == ($past(state) == SHIFT_DR || $past(state) == SHIFT_IR);
  endproperty
  a_oe_shift_only: assert property (p_oe_shift_only) // R4
    else $error("serial output enable wrong for the controller state");

  property p_five_high_reset;
    tckRise && linkSync.tms && tmsHighEdges >= 3'(RESET_TMS_EDGES - 1) |=> state == TLR;
  endproperty
  a_five_high_reset: assert property (p_five_high_reset) // R5
    else $error("five high mode-select edges did not reach reset");

  property p_path_output;
    tckFall && state == SHIFT_DR && path == PATH_ID |=> tdo == $past(idShift[0]);
  endproperty
  a_path_output: assert property (p_path_output) // R7
    else $error("serial output not taken from the selected register");

  property p_reset_insn;
    state == TLR ##1 state == TLR |-> irActive == INSN_READ_ID;
  endproperty
  a_reset_insn: assert property (p_reset_insn) // R8
    else $error("held instruction not identification read in reset");

  property p_capture_ir;
    tckRise && state == CAPTURE_IR |=> irShift[1:0] == IR_CAPTURE_PATTERN;
  endproperty
  a_capture_ir: assert property (p_capture_ir) // R9
    else $error("capture-instruction pattern missing");

  property p_bypass_clear;
    tckRise && state == CAPTURE_DR && path == PATH_BYPASS |=> bypassBit == BYPASS_CAPTURE;
  endproperty
  a_bypass_clear: assert property (p_bypass_clear) // R10
    else $error("bypass bit not cleared on capture");

  property p_ring_capture;
    tckRise && state == CAPTURE_DR && path == PATH_RING |=> pinScanChain == $past(ringSync);
  endproperty
  a_ring_capture: assert property (p_ring_capture) // R11
    else $error("ring register did not capture pin state");

  property p_id_capture;
    tckRise && state == CAPTURE_DR && path == PATH_ID |=> idShift == ID_WORD;
  endproperty
  a_id_capture: assert property (p_id_capture) // R12
    else $error("identification word not captured");

  property p_insn_update;
    !$stable(irActive) |-> $past(state) == UPDATE_IR || $past(state) == TLR;
  endproperty
  a_insn_update: assert property (p_insn_update) // R13
    else $error("held instruction changed outside update-instruction");

  property p_high_z;
    ##1 outputsHighZ == ($past(irActive) == INSN_EXT_TEST || $past(irActive) == INSN_SAMPLE_HIZ);
  endproperty
  a_high_z: assert property (p_high_z) // R15
    else $error("memory output high-impedance request wrong");

  property p_update_dr_idle;
    state == UPDATE_DR |=> $stable(pinScanChain);
  endproperty
  a_update_dr_idle: assert property (p_update_dr_idle) // R18
    else $error("update-data altered the ring register");

endmodule

// ==== bench/jtag_ctrl_model.sv ====
`timescale 1ns/1ps
module jtag_ctrl_model
  import sram_tap_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic tdo,
  input  wire logic tdoOe,
  output link_in_t  link
);
  logic lastTdo = 1'b0;
  logic tdoLine;

  // A released serial output shows the inverse of its last driven value.
  assign tdoLine = tdoOe ? tdo : ~lastTdo;

  always @(posedge sys_clk) begin
    if (tdoOe) begin
      lastTdo <= tdo;
    end
  end

  // Mode select and serial input read high, as their pull-ups make them; the test clock starts low.
  initial begin
    link = LINK_IDLE;
  end

  // One test clock period of 8 system cycles, low 4 and high 4.
  task automatic step(input logic tmsV, input logic tdiV, output logic tdoV, output logic oeV);
    link.tck <= 1'b0;
    link.tms <= tmsV;
    link.tdi <= tdiV;
    repeat (4) @(negedge sys_clk);
    tdoV = tdoLine;
    oeV = tdoOe;
    link.tck <= 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask

  // The test clock stands low between frames.
  task automatic idle();
    link.tck <= 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask

  // Runs from the idle state through capture, shift and update back to idle.
  task automatic scan(input logic isIr, input logic [127:0] din, input int n,
                      output logic [127:0] dout, output logic oeAll);
    logic t;
    logic o;
    dout = '0;
    oeAll = 1'b1;
    step(1'b0, 1'b1, t, o);
    step(1'b1, 1'b1, t, o);
    if (isIr) begin
      step(1'b1, 1'b1, t, o);
    end
    step(1'b0, 1'b1, t, o);
    step(1'b0, 1'b1, t, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], t, o);
      dout[i] = t;
      oeAll = oeAll & o;
    end
    step(1'b1, 1'b1, t, o);
    step(1'b0, 1'b1, t, o);
    idle();
  endtask
endmodule

// ==== bench/sram_boundary_scan_tap_tb.sv ====
`timescale 1ns/1ps
`define CHECK(nm, exp, got) \
  begin \
    checkCount++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("[ERR] %s expected %h seen %h", nm, exp, got); \
    end \
  end

module sram_boundary_scan_tap_tb;
  import sram_tap_pkg::*;
  logic                 sysClk = 1'b0;
  logic                 rstN = 1'b0;
  link_in_t             link;
  logic [BSR_WIDTH-1:0] ioRing = '0;
  logic                 tdo;
  logic                 tdoOe;
  logic                 outputsHighZ;
  int                   failures = 0;
  int                   checkCount = 0;
  int                   cycles = 0;

  sram_boundary_scan_tap #(
    .BSR_LEN (BSR_WIDTH),
    .ID_WORD (ID_WORD_DEFAULT)
  ) i_sram_boundary_scan_tap (
    .sys_clk      (sysClk),
    .rst_n        (rstN),
    .tck          (link.tck),
    .tms          (link.tms),
    .tdi          (link.tdi),
    .ioRing       (ioRing),
    .tdo          (tdo),
    .tdoOe        (tdoOe),
    .outputsHighZ (outputsHighZ)
  );

  jtag_ctrl_model i_jtag_ctrl_model (
    .sys_clk (sysClk),
    .tdo     (tdo),
    .tdoOe   (tdoOe),
    .link    (link)
  );

  always #20 sysClk = ~sysClk;

  task automatic finalReport();
    if (failures == 0 && checkCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge sysClk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      finalReport();
    end
  end

  task automatic loadIr(input logic [2:0] code, output logic [2:0] cap);
    logic [127:0] q;
    logic oe;
    i_jtag_ctrl_model.scan(1'b1, {125'h0, code}, 3, q, oe);
    cap = q[2:0];
    `CHECK("ir shift enable", 1'b1, oe)
  endtask

  initial begin
    logic [127:0] q;
    logic [127:0] din;
    logic [BSR_WIDTH-1:0] ring;
    logic [2:0] cap;
    logic oe;
    repeat (8) @(negedge sysClk);
    rstN = 1'b1;
    repeat (3) @(negedge sysClk);
    `CHECK("enable after reset", 1'b0, tdoOe)
    `CHECK("hiz after reset", 1'b0, outputsHighZ)
    din = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
    i_jtag_ctrl_model.scan(1'b0, din, 34, q, oe);
    `CHECK("id word", ID_WORD_DEFAULT, q[31:0])
    `CHECK("id tail", din[1:0], q[33:32])
    for (int c = 0; c < 8; c++) begin
      ring = {3{25'h0ab_cdef}} ^ {25{3'(c)}};
      ioRing = ring;
      loadIr(3'(c), cap);
      `CHECK("ir capture", 3'h1, cap)
      `CHECK("hiz", logic'(c == 0 || c == 2), outputsHighZ)
      i_jtag_ctrl_model.scan(1'b0, din, 80, q, oe);
      `CHECK("dr shift enable", 1'b1, oe)
      `CHECK("enable idle", 1'b0, tdoOe)
      `CHECK("hiz kept", logic'(c == 0 || c == 2), outputsHighZ)
      case (c)
        1: `CHECK("id path", {din[47:0], ID_WORD_DEFAULT}, q[79:0])
        0, 2, 4: `CHECK("ring path", {din[4:0], ring}, q[79:0])
        default: `CHECK("bypass path", {din[78:0], 1'b0}, q[79:0])
      endcase
    end
    loadIr(3'h0, cap);
    for (int i = 0; i < 8; i++) begin
      i_jtag_ctrl_model.step(logic'(8'hf2 >> i), 1'b1, cap[0], oe);
    end
    `CHECK("hiz after four", 1'b1, outputsHighZ)
    i_jtag_ctrl_model.step(1'b1, 1'b1, cap[0], oe);
    i_jtag_ctrl_model.idle();
    `CHECK("hiz after five", 1'b0, outputsHighZ)
    i_jtag_ctrl_model.scan(1'b0, din, 32, q, oe);
    `CHECK("id after tms reset", ID_WORD_DEFAULT, q[31:0])
    // Identification read split by a pause, through both exit states.
    q = '0;
    i_jtag_ctrl_model.step(1'b1, 1'b1, cap[0], oe);
    i_jtag_ctrl_model.step(1'b0, 1'b1, cap[0], oe);
    i_jtag_ctrl_model.step(1'b0, 1'b1, cap[0], oe);
    for (int i = 0; i < 16; i++) begin
      i_jtag_ctrl_model.step(logic'(i == 15), 1'b1, q[i], oe);
    end
    i_jtag_ctrl_model.step(1'b0, 1'b1, cap[0], oe);
    i_jtag_ctrl_model.step(1'b0, 1'b1, cap[0], oe);
    `CHECK("enable in pause", 1'b0, oe)
    i_jtag_ctrl_model.step(1'b1, 1'b1, cap[0], oe);
    i_jtag_ctrl_model.step(1'b0, 1'b1, cap[0], oe);
    for (int i = 16; i < 32; i++) begin
      i_jtag_ctrl_model.step(logic'(i == 31), 1'b1, q[i], oe);
    end
    i_jtag_ctrl_model.step(1'b1, 1'b1, cap[0], oe);
    i_jtag_ctrl_model.step(1'b0, 1'b1, cap[0], oe);
    i_jtag_ctrl_model.idle();
    `CHECK("id across pause", ID_WORD_DEFAULT, q[31:0])
    `CHECK("enable after pause frame", 1'b0, tdoOe)
    loadIr(3'h2, cap);
    `CHECK("hiz before reset", 1'b1, outputsHighZ)
    rstN = 1'b0;
    repeat (3) @(negedge sysClk);
    rstN = 1'b1;
    repeat (3) @(negedge sysClk);
    `CHECK("hiz mid reset", 1'b0, outputsHighZ)
    `CHECK("enable mid reset", 1'b0, tdoOe)
    finalReport();
  end
endmodule
